// [core/prs_pkg.sv]
`default_nettype none
package prs_pkg;

  // ***************************************
  // clock and timing
  // ***************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILT_MIN_NS = 475;
  localparam int FILT_MAX_NS = 2000;
  // least time, rounded up to whole cycles
  localparam logic [7:0] FILT_CYC =
    8'((FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ***************************************
  // power-up phases, oscillator cycles
  // ***************************************
  localparam logic [11:0] OSC_CHECK_CYC = 12'h408; // 1032 cycles
  localparam logic [11:0] FUSE_LOAD_CYC = 12'h488; // 1160 cycles
  localparam logic [11:0] PUMP_UP_CYC = 12'h2B0; // 688 cycles
  localparam logic [11:0] BANK_UP_CYC = 12'h269; // 617 cycles
  localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;

  // ***************************************
  // warm reset pin hold times
  // ***************************************
  localparam logic [11:0] POR_HOLD_CYC = 12'h8D0; // 2256 cycles
  localparam logic [5:0] WARM_HOLD_PCLK = 6'h20; // 32 enables

  // ***************************************
  // status flag positions
  // ***************************************
  localparam int EXC_POR_BIT = 15;
  localparam int EXC_WDOG_BIT = 13;
  localparam int EXC_STC_BIT = 5;
  localparam int EXC_SW_BIT = 4;
  localparam int EXC_EXT_BIT = 3;
  localparam int GLB_OSC_BIT = 0;
  localparam int GLB_SLIP_LO_BIT = 8;
  localparam int GLB_SLIP_HI_BIT = 9;
  localparam logic [15:0] STATUS_RST = 16'h0000;

  // ***************************************
  // sequencer states
  // ***************************************
  typedef enum logic [6:0] {
    st_por = 7'h01,
    st_osc = 7'h02,
    st_fuse = 7'h04,
    st_pump = 7'h08,
    st_bank = 7'h10,
    st_run = 7'h20,
    st_warm = 7'h40
  } prs_state_t;

endpackage
`default_nettype wire

// [core/prs_glitch_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module prs_glitch_filter #(
  parameter logic [7:0] THRESH = prs_pkg::FILT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // pin and filtered level
  input wire logic pin_n,
  output logic filt_low
);

  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;
  logic next_filt_low;

  // count consecutive low samples, a high sample clears at once
  always_comb begin
    next_low_cnt = low_cnt;
    if (pin_n) begin
      next_low_cnt = 8'h00;
    end else if (low_cnt < THRESH) begin
      next_low_cnt = low_cnt + 8'h01;
    end
    next_filt_low = (next_low_cnt >= THRESH);
  end

  // a low shorter than the threshold never reaches the output
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // reset reads as a long low, so no false release follows it
      low_cnt <= THRESH;
      filt_low <= 1'b1;
    end else begin
      low_cnt <= next_low_cnt;
      filt_low <= next_filt_low;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  filt_high_a: assert property (pin_n |=> !filt_low)
    else $error("filter stayed low after a high sample");
  filt_rise_a: assert property (
    $rose(filt_low) |-> !$past(pin_n) && !$past(pin_n, THRESH))
    else $error("filter asserted on a short low pulse");

endmodule
`default_nettype wire

// [core/prs_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer #(
  parameter int LS_W = 32,
  parameter int PCLK_DIV = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // supply monitor
  input wire logic supply_io_good,
  input wire logic supply_core_good,
  // reset pins
  input wire logic power_on_reset_in_n,
  input wire logic warm_reset_pin_n_in,
  output logic warm_reset_pin_n_out,
  output logic warm_reset_pin_n_oe,
  // reset causes
  input wire logic osc_fail,
  input wire logic [1:0] pll_slip,
  input wire logic wdog_or_debug_req,
  input wire logic stc_cpu_reset_req,
  input wire logic sw_reset_req,
  // status flags, write one to clear
  input wire logic [15:0] exc_clear,
  input wire logic [15:0] glb_clear,
  output logic [15:0] exc_status,
  output logic [15:0] glb_status,
  // cpu control
  output logic cpu_rst_n,
  output logic [31:0] cpu_boot_addr,
  output logic outputs_hiz,
  input wire logic feat_wr,
  input wire logic [2:0] feat_data,
  output logic cpu_tcm_ecc_en,
  output logic cpu_vec_irq_en,
  output logic cpu_mpu_en,
  // lockstep compare
  input wire logic [LS_W-1:0] cpu1_out,
  input wire logic [LS_W-1:0] cpu2_out,
  output logic compare_error
);

  // ***************************************
  // pin filters and power-on condition
  // ***************************************
  logic por_filt_low;
  logic pin_filt_low;
  logic por_active;
  logic drive_d1;
  logic ext_req;
  logic warm_evt;

  prs_glitch_filter u_por_filt (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_n(power_on_reset_in_n),
    .filt_low(por_filt_low)
  );

  prs_glitch_filter u_pin_filt (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_n(warm_reset_pin_n_in),
    .filt_low(pin_filt_low)
  );

  // supply loss acts as power-on reset; the pin relies on the supervisor
  assign por_active = por_filt_low | ~supply_io_good | ~supply_core_good;
  // our own drive pulls the pin low, so mask it and one cycle of release
  assign ext_req = pin_filt_low & ~warm_reset_pin_n_oe & ~drive_d1;
  assign warm_evt = wdog_or_debug_req | stc_cpu_reset_req | sw_reset_req |
                    ext_req | osc_fail | (|pll_slip);

  // ***************************************
  // peripheral clock enable
  // ***************************************
  logic [7:0] pdiv_cnt;
  logic [7:0] next_pdiv_cnt;
  logic pclk_en;
  logic next_pclk_en;

  // divider stands in for the peripheral clock
  always_comb begin
    next_pclk_en = (pdiv_cnt == 8'(PCLK_DIV - 1));
    next_pdiv_cnt = next_pclk_en ? 8'h00 : pdiv_cnt + 8'h01;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pdiv_cnt <= 8'h00;
      pclk_en <= 1'b0;
    end else begin
      pdiv_cnt <= next_pdiv_cnt;
      pclk_en <= next_pclk_en;
    end
  end

  // ***************************************
  // power-up sequencer
  // ***************************************
  prs_pkg::prs_state_t state;
  prs_pkg::prs_state_t next_state;
  logic [11:0] phase_cnt;
  logic [11:0] next_phase_cnt;

  // each phase counts down from its length minus one
  always_comb begin
    next_state = state;
    next_phase_cnt = (phase_cnt != 12'h000) ? phase_cnt - 12'h001 : 12'h000;
    case (state)
      prs_pkg::st_por: begin
        if (!por_active) begin
          next_state = prs_pkg::st_osc;
          next_phase_cnt = prs_pkg::OSC_CHECK_CYC - 12'h001;
        end
      end
      prs_pkg::st_osc: begin
        if (phase_cnt == 12'h000) begin
          next_state = prs_pkg::st_fuse;
          next_phase_cnt = prs_pkg::FUSE_LOAD_CYC - 12'h001;
        end
      end
      prs_pkg::st_fuse: begin
        if (phase_cnt == 12'h000) begin
          next_state = prs_pkg::st_pump;
          next_phase_cnt = prs_pkg::PUMP_UP_CYC - 12'h001;
        end
      end
      prs_pkg::st_pump: begin
        if (phase_cnt == 12'h000) begin
          next_state = prs_pkg::st_bank;
          next_phase_cnt = prs_pkg::BANK_UP_CYC - 12'h001;
        end
      end
      prs_pkg::st_bank: begin
        if (phase_cnt == 12'h000) begin
          next_state = prs_pkg::st_run;
        end
      end
      prs_pkg::st_run: begin
        if (warm_evt) begin
          next_state = prs_pkg::st_warm;
        end
      end
      prs_pkg::st_warm: begin
        // leave only once the pin is free and nothing asks again
        if (!warm_reset_pin_n_oe && !drive_d1 && !pin_filt_low && !warm_evt) begin
          next_state = prs_pkg::st_run;
        end
      end
      default: begin
        next_state = prs_pkg::st_por;
      end
    endcase
    if (por_active) begin
      next_state = prs_pkg::st_por;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= prs_pkg::st_por;
      phase_cnt <= 12'h000;
    end else begin
      state <= next_state;
      phase_cnt <= next_phase_cnt;
    end
  end

  // ***************************************
  // warm reset pin drive
  // ***************************************
  logic [11:0] por_hold;
  logic [11:0] next_por_hold;
  logic [5:0] warm_hold;
  logic [5:0] next_warm_hold;
  logic next_drive;

  // two counters, so a short warm hold never cuts the power-on hold
  always_comb begin
    next_por_hold = por_hold;
    next_warm_hold = warm_hold;
    if (por_active) begin
      next_por_hold = prs_pkg::POR_HOLD_CYC;
    end else if (por_hold != 12'h000) begin
      next_por_hold = por_hold - 12'h001;
    end
    if (warm_evt && !por_active) begin
      next_warm_hold = prs_pkg::WARM_HOLD_PCLK;
    end else if (pclk_en && warm_hold != 6'h00) begin
      next_warm_hold = warm_hold - 6'h01;
    end
    next_drive = por_active | (next_por_hold != 12'h000) |
                 (next_warm_hold != 6'h00);
  end

  // open drain: the data bit is always low, only the enable moves
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      por_hold <= 12'h000;
      warm_hold <= 6'h00;
      warm_reset_pin_n_oe <= 1'b1;
      warm_reset_pin_n_out <= 1'b0;
      drive_d1 <= 1'b1;
    end else begin
      por_hold <= next_por_hold;
      warm_hold <= next_warm_hold;
      warm_reset_pin_n_oe <= next_drive;
      warm_reset_pin_n_out <= 1'b0;
      drive_d1 <= warm_reset_pin_n_oe;
    end
  end

  // ***************************************
  // cause flags, cpu control, compare
  // ***************************************
  logic [15:0] exc_set;
  logic [15:0] glb_set;
  logic [15:0] next_exc;
  logic [15:0] next_glb;
  logic [2:0] next_feat;
  logic [LS_W-1:0] cpu1_d1;
  logic [LS_W-1:0] cpu1_d2;

  // set wins over clear; only sys_rst wipes, so causes outlive warm reset
  always_comb begin
    exc_set = 16'h0000;
    glb_set = 16'h0000;
    exc_set[prs_pkg::EXC_POR_BIT] = por_active;
    exc_set[prs_pkg::EXC_WDOG_BIT] = wdog_or_debug_req;
    exc_set[prs_pkg::EXC_STC_BIT] = stc_cpu_reset_req;
    exc_set[prs_pkg::EXC_SW_BIT] = sw_reset_req;
    exc_set[prs_pkg::EXC_EXT_BIT] = ext_req;
    glb_set[prs_pkg::GLB_OSC_BIT] = osc_fail;
    glb_set[prs_pkg::GLB_SLIP_LO_BIT] = pll_slip[0];
    glb_set[prs_pkg::GLB_SLIP_HI_BIT] = pll_slip[1];
    next_exc = (exc_status & ~exc_clear) | exc_set;
    next_glb = (glb_status & ~glb_clear) | glb_set;
    next_feat = {cpu_mpu_en, cpu_vec_irq_en, cpu_tcm_ecc_en};
    if (next_state != prs_pkg::st_run) begin
      next_feat = 3'h0;
    end else if (feat_wr) begin
      next_feat = feat_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      exc_status <= prs_pkg::STATUS_RST;
      glb_status <= prs_pkg::STATUS_RST;
      cpu_rst_n <= 1'b0;
      cpu_boot_addr <= prs_pkg::BOOT_ADDR;
      outputs_hiz <= 1'b1;
      {cpu_mpu_en, cpu_vec_irq_en, cpu_tcm_ecc_en} <= 3'h0;
      cpu1_d1 <= '0;
      cpu1_d2 <= '0;
      compare_error <= 1'b0;
    end else begin
      exc_status <= next_exc;
      glb_status <= next_glb;
      cpu_rst_n <= (next_state == prs_pkg::st_run);
      cpu_boot_addr <= prs_pkg::BOOT_ADDR;
      outputs_hiz <= ~supply_core_good;
      {cpu_mpu_en, cpu_vec_irq_en, cpu_tcm_ecc_en} <= next_feat;
      // skew breaks common-mode faults between the two cores
      cpu1_d1 <= cpu1_out;
      cpu1_d2 <= cpu1_d1;
      compare_error <= (cpu1_d2 != cpu2_out);
    end
  end

  // ***************************************
  // checks
  // ***************************************
  logic [11:0] age;
  logic [11:0] age_por;
  logic [5:0] evt_pcnt;

  // helpers: time in state, since power-on release, since a warm event
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      age <= 12'h000;
      age_por <= 12'h000;
      evt_pcnt <= 6'h3F;
    end else begin
      age <= (next_state != state) ? 12'h000 :
             (age == 12'hFFF) ? age : age + 12'h001;
      age_por <= por_active ? 12'h000 :
                 (age_por == 12'hFFF) ? age_por : age_por + 12'h001;
      evt_pcnt <= (warm_evt && !por_active) ? 6'h00 :
                  (pclk_en && evt_pcnt != 6'h3F) ? evt_pcnt + 6'h01 : evt_pcnt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence bank_end;
    state == prs_pkg::st_bank && phase_cnt == 12'h000 && !por_active;
  endsequence

  hold_in_por_a: assert property (por_active |=> state == prs_pkg::st_por)
    else $error("sequence left power-on state while reset active");
  osc_len_a: assert property (
    state == prs_pkg::st_osc && next_state == prs_pkg::st_fuse |->
    age == prs_pkg::OSC_CHECK_CYC - 12'h001)
    else $error("oscillator phase length wrong");
  fuse_len_a: assert property (
    state == prs_pkg::st_fuse && next_state == prs_pkg::st_pump |->
    age == prs_pkg::FUSE_LOAD_CYC - 12'h001)
    else $error("fuse phase length wrong");
  pump_len_a: assert property (
    state == prs_pkg::st_pump && next_state == prs_pkg::st_bank |->
    age == prs_pkg::PUMP_UP_CYC - 12'h001)
    else $error("pump phase length wrong");
  bank_len_a: assert property (
    bank_end |-> age == prs_pkg::BANK_UP_CYC - 12'h001)
    else $error("bank phase length wrong");
  cpu_release_a: assert property (
    bank_end |=> cpu_rst_n && cpu_boot_addr == prs_pkg::BOOT_ADDR)
    else $error("cpu reset not released after bank phase");
  pin_low_only_a: assert property (!warm_reset_pin_n_out)
    else $error("warm reset pin driven high");
  por_hold_a: assert property (
    age_por < prs_pkg::POR_HOLD_CYC |-> warm_reset_pin_n_oe)
    else $error("warm reset pin released early after power-on");
  warm_hold_a: assert property (
    evt_pcnt < prs_pkg::WARM_HOLD_PCLK |-> warm_reset_pin_n_oe)
    else $error("warm reset pin released before 32 peripheral clocks");
  ext_flag_a: assert property (
    pin_filt_low && !warm_reset_pin_n_oe && !drive_d1 |=>
    exc_status[prs_pkg::EXC_EXT_BIT] ##[0:1] warm_reset_pin_n_oe)
    else $error("external warm reset not taken");
  cause_flag_a: assert property (
    wdog_or_debug_req || sw_reset_req |=>
    exc_status[prs_pkg::EXC_WDOG_BIT] || exc_status[prs_pkg::EXC_SW_BIT])
    else $error("reset cause flag not set");
  osc_fail_a: assert property (
    osc_fail && !por_active |=> glb_status[prs_pkg::GLB_OSC_BIT] &&
    warm_reset_pin_n_oe && !cpu_rst_n)
    else $error("oscillator fail not flagged or not reset");
  flag_keep_a: assert property (
    exc_status[prs_pkg::EXC_POR_BIT] && !exc_clear[prs_pkg::EXC_POR_BIT] |=>
    exc_status[prs_pkg::EXC_POR_BIT])
    else $error("power-up flag lost without clear");
  feat_off_a: assert property (
    !cpu_rst_n |-> !cpu_mpu_en && !cpu_vec_irq_en && !cpu_tcm_ecc_en)
    else $error("cpu feature on while cpu in reset");
  lockstep_skew_a: assert property (
    ##3 compare_error == ($past(cpu1_out, 3) != $past(cpu2_out)))
    else $error("lockstep compare skew wrong");

endmodule
`default_nettype wire

// [testbench/prs_supervisor_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ***************************************
// external reset supervisor and warm reset pin
// ***************************************
module prs_supervisor_model (
  // supplies and commands from the bench
  input wire logic supply_io_good,
  input wire logic supply_core_good,
  input wire logic por_req,
  input wire logic ext_pull,
  // device side of the warm reset pin
  input wire logic dev_oe,
  input wire logic dev_out,
  // resolved pin levels
  output logic power_on_reset_in_n,
  output logic warm_pin_n
);
  // supervisor holds power-on low while a supply is out of range
  assign power_on_reset_in_n =
    ~(por_req | ~supply_io_good | ~supply_core_good);
  // open drain wire with pullup, either party may pull it low
  assign warm_pin_n =
    ((dev_oe & ~dev_out) | ext_pull) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// [testbench/prs_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer_tb;
  // ***************************************
  // signals
  // ***************************************
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic io_ok = 1'b1;
  logic core_ok = 1'b1;
  logic por_req = 1'b1;
  logic ext_pull = 1'b0;
  logic por_n, pin_n, pin_out, pin_oe;
  logic osc_fail = 1'b0;
  logic [1:0] pll_slip = 2'h0;
  logic wdog = 1'b0;
  logic cpu_self_test_controller = 1'b0;
  logic swr = 1'b0;
  logic [15:0] exc_clear = 16'h0000;
  logic [15:0] glb_clear = 16'h0000;
  logic [15:0] exc_status, glb_status;
  logic cpu_rst_n, outputs_hiz, ecc_en, vec_en, mpu_en, cmp_err;
  logic [31:0] boot_addr;
  logic feat_wr = 1'b0;
  logic [2:0] feat_data = 3'h0;
  logic [31:0] cpu1 = 32'h0000_0000;
  logic [31:0] cpu2 = 32'h0000_0000;
  int failures = 0;
  int checks_done = 0;

  always #10 ref_clk = ~ref_clk;

  prs_supervisor_model sup (
    .supply_io_good(io_ok), .supply_core_good(core_ok),
    .por_req(por_req), .ext_pull(ext_pull),
    .dev_oe(pin_oe), .dev_out(pin_out),
    .power_on_reset_in_n(por_n), .warm_pin_n(pin_n)
  );

  prs_sequencer #(.LS_W(32), .PCLK_DIV(2)) uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .supply_io_good(io_ok), .supply_core_good(core_ok),
    .power_on_reset_in_n(por_n), .warm_reset_pin_n_in(pin_n),
    .warm_reset_pin_n_out(pin_out), .warm_reset_pin_n_oe(pin_oe),
    .osc_fail(osc_fail), .pll_slip(pll_slip),
    .wdog_or_debug_req(wdog), .stc_cpu_reset_req(cpu_self_test_controller),
    .sw_reset_req(swr), .exc_clear(exc_clear), .glb_clear(glb_clear),
    .exc_status(exc_status), .glb_status(glb_status),
    .cpu_rst_n(cpu_rst_n), .cpu_boot_addr(boot_addr),
    .outputs_hiz(outputs_hiz), .feat_wr(feat_wr),
    .feat_data(feat_data), .cpu_tcm_ecc_en(ecc_en),
    .cpu_vec_irq_en(vec_en), .cpu_mpu_en(mpu_en),
    .cpu1_out(cpu1), .cpu2_out(cpu2), .compare_error(cmp_err)
  );

  // ***************************************
  // helpers
  // ***************************************
  // inputs always move 2 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // bounded wait for the cpu to leave reset
  task automatic wait_run(input int limit, output int n);
    n = 0;
    while (cpu_rst_n !== 1'b1 && n < limit) begin
      step(1);
      n++;
    end
  endtask

  task automatic clear_flags();
    exc_clear = 16'hFFFF;
    glb_clear = 16'hFFFF;
    step(1);
    exc_clear = 16'h0000;
    glb_clear = 16'h0000;
  endtask

  // ***************************************
  // scenarios
  // ***************************************
  // full cold start, timed from the power-on release
  task automatic power_up();
    int n;
    por_req = 1'b1;
    step(40);
    chk(cpu_rst_n === 1'b0 && exc_status[15] === 1'b1, "por hold");
    por_req = 1'b0;
    n = 0;
    while (cpu_rst_n !== 1'b1 && n < 4000) begin
      step(1);
      n++;
      if (n == 2250) chk(pin_oe === 1'b1 && pin_out === 1'b0, "pin hold");
    end
    chk(n >= 3497 && n <= 3500, "phase total");
    chk(boot_addr === 32'h0000_0000, "boot address");
    chk({ecc_en, vec_en, mpu_en} === 3'h0, "features on");
    chk(pin_oe === 1'b0, "pin still driven");
  endtask

  // short lows ignored, long lows restart the cold start
  task automatic por_filter();
    int n;
    por_req = 1'b1;
    step(20);
    por_req = 1'b0;
    step(5);
    chk(cpu_rst_n === 1'b1, "por glitch taken");
    por_req = 1'b1;
    step(101);
    chk(cpu_rst_n === 1'b0, "por long ignored");
    por_req = 1'b0;
    wait_run(4000, n);
    chk(n >= 3497, "por restart short");
  endtask

  // a low supply keeps the cpu in reset, with the supervisor holding the power-on pin low
  task automatic supply_low();
    int n;
    core_ok = 1'b0;
    step(3);
    chk(outputs_hiz === 1'b1, "no float on core fault");
    chk(cpu_rst_n === 1'b0, "run on core fault");
    core_ok = 1'b1;
    io_ok = 1'b0;
    step(3);
    chk(outputs_hiz === 1'b0, "float stuck");
    step(3600);
    chk(cpu_rst_n === 1'b0, "run with io low");
    io_ok = 1'b1;
    wait_run(4000, n);
    chk(n >= 3497, "io restart short");
  endtask

  // every internal cause: flag, pin hold, restart, flag kept
  task automatic warm_causes();
    int n;
    for (int i = 0; i < 6; i++) begin
      clear_flags();
      case (i)
        0: osc_fail = 1'b1;
        1: pll_slip = 2'h1;
        2: pll_slip = 2'h2;
        3: wdog = 1'b1;
        4: cpu_self_test_controller = 1'b1;
        default: swr = 1'b1;
      endcase
      step(1);
      {osc_fail, pll_slip, wdog, cpu_self_test_controller, swr} = 6'h00;
      step(1);
      chk(cpu_rst_n === 1'b0 && pin_oe === 1'b1, "no warm reset");
      case (i)
        0: chk(glb_status === 16'h0001, "osc flag");
        1: chk(glb_status === 16'h0100, "slip lo flag");
        2: chk(glb_status === 16'h0200, "slip hi flag");
        3: chk(exc_status === 16'h2000, "wdog flag");
        4: chk(exc_status === 16'h0020, "stc flag");
        default: chk(exc_status === 16'h0010, "sw flag");
      endcase
      step(60);
      chk(pin_oe === 1'b1 && pin_out === 1'b0, "pin released early");
      wait_run(300, n);
      chk(cpu_rst_n === 1'b1, "no return to run");
      chk((exc_status | glb_status) !== 16'h0000, "flag lost");
    end
    clear_flags();
    chk(exc_status === 16'h0000 && glb_status === 16'h0000, "clear");
  endtask

  // external pull on the warm pin, short then long
  task automatic ext_reset();
    int n;
    ext_pull = 1'b1;
    step(10);
    ext_pull = 1'b0;
    step(3);
    chk(exc_status[3] === 1'b0 && cpu_rst_n === 1'b1, "pin glitch");
    ext_pull = 1'b1;
    step(101);
    chk(exc_status[3] === 1'b1 && cpu_rst_n === 1'b0, "ext missed");
    ext_pull = 1'b0;
    wait_run(400, n);
    chk(cpu_rst_n === 1'b1 && exc_status[3] === 1'b1, "ext return");
    clear_flags();
  endtask

  // software enables, then a reset turns them off again
  task automatic features();
    int n;
    feat_data = 3'h7;
    feat_wr = 1'b1;
    step(1);
    feat_wr = 1'b0;
    step(1);
    chk({ecc_en, vec_en, mpu_en} === 3'h7, "feature write");
    swr = 1'b1;
    step(1);
    swr = 1'b0;
    step(2);
    chk({ecc_en, vec_en, mpu_en} === 3'h0, "features kept");
    wait_run(300, n);
    clear_flags();
  endtask

  // second cpu lags by two cycles: quiet; no lag: error
  task automatic lockstep();
    logic [31:0] hist [0:2];
    for (int k = 0; k < 12; k++) begin
      hist[2] = hist[1];
      hist[1] = hist[0];
      hist[0] = 32'h1111_1111 * k;
      cpu1 = hist[0];
      if (k >= 2) cpu2 = hist[2];
      step(1);
      if (k >= 6) chk(cmp_err === 1'b0, "false compare");
    end
    cpu1 = 32'hA5A5_0001;
    cpu2 = 32'hA5A5_0001;
    step(1);
    chk(cmp_err === 1'b1, "missed compare");
    step(2);
    chk(cmp_err === 1'b0, "compare stuck");
    cpu2 = cpu1;
  endtask

  // ***************************************
  // sequence, verdict and watchdog
  // ***************************************
  task automatic report_and_stop();
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    step(4);
    sys_rst = 1'b0;
    power_up();
    por_filter();
    supply_low();
    clear_flags();
    warm_causes();
    ext_reset();
    features();
    lockstep();
    report_and_stop();
  end

  // about three times the expected run length
  initial begin
    #1000000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
